// ===== rtl/pmm_pkg.sv
// shared constants and types for the program and data memory map block
package pmm_pkg;

  typedef enum logic [2:0] {
    VAR_W384,
    VAR_W512,
    VAR_W512_PORT3,
    VAR_W1K,
    VAR_W2K_PORT3,
    VAR_W2K
  } pmm_variant_t;

  typedef enum logic [1:0] {
    QTR_FIRST,
    QTR_SECOND,
    QTR_THIRD,
    QTR_FOURTH
  } pmm_quarter_t;

  localparam int PMM_PC_W = 11;
  localparam int PMM_FA_W = 5;

  // program store sizes in 12-bit words
  localparam logic [11:0] WORDS_384 = 12'h180;
  localparam logic [11:0] WORDS_512 = 12'h200;
  localparam logic [11:0] WORDS_1K = 12'h400;
  localparam logic [11:0] WORDS_2K = 12'h800;

  // file addresses
  localparam logic [4:0] ADDR_INDIRECT_WINDOW = 5'h00;
  localparam logic [4:0] ADDR_REALTIME_COUNTER = 5'h01;
  localparam logic [4:0] ADDR_PROGRAM_COUNTER_LOW = 5'h02;
  localparam logic [4:0] ADDR_ALU_RESET_PAGE_FLAGS = 5'h03;
  localparam logic [4:0] ADDR_INDIRECT_POINTER = 5'h04;
  localparam logic [4:0] ADDR_FIRST_IO_PORT = 5'h05;
  localparam logic [4:0] ADDR_SECOND_IO_PORT = 5'h06;
  localparam logic [4:0] ADDR_THIRD_IO_PORT = 5'h07;
  localparam logic [4:0] ADDR_COMMON_GPR_BASE = 5'h08;

  // flag register bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_POWER_DOWN = 3;
  localparam int FLAG_WATCHDOG_TIMEOUT = 4;
  localparam int FLAG_PAGE_LSB = 5;
  localparam int FLAG_PAGE_MSB = 7;

  // reset values
  localparam logic [2:0] RST_PAGE_BITS = 3'h0;
  localparam logic [7:0] RST_INDIRECT_POINTER = 8'h80;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hFF;
  localparam logic [5:0] RST_TIMER_PRESCALER = 6'h3F;

  // pointer bits that have no storage read back as ones
  localparam logic [2:0] POINTER_FILL_UNBANKED = 3'h7;
  localparam logic POINTER_FILL_BANKED = 1'b1;

  // general purpose byte store: four banks of 16 plus the common block
  localparam int GPR_DEPTH = 80;
  localparam int GPR_AW = 7;
  localparam logic [2:0] GPR_COMMON_TAG = 3'h4;

  localparam int FIRST_PORT_W = 4;
  localparam logic [3:0] FIRST_PORT_PAD = 4'h0;

endpackage

// ===== rtl/pmm_gpr_mem.sv
// general purpose byte store with registered read data
`timescale 1ns/100ps
`default_nettype none
module pmm_gpr_mem
  import pmm_pkg::*;
#(
  parameter int DEPTH = GPR_DEPTH,
  parameter int AW = GPR_AW
)
(
  input wire logic clk_sys,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData_q,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData
);

  logic [7:0] store [DEPTH];

  // contents are undefined after reset, like the bytes they model
  always_ff @(posedge clk_sys)
  begin
    if (wrEn && (int'(wrAddr) < DEPTH))
    begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rdEn)
    begin
      rdData_q <= (int'(rdAddr) < DEPTH) ? store[rdAddr] : 8'h00;
    end
  end

endmodule // pmm_gpr_mem
`default_nettype wire

// ===== rtl/pmm_prog_counter.sv
// program counter with size-dependent width, wraparound and reset vector
`timescale 1ns/100ps
`default_nettype none
module pmm_prog_counter
  import pmm_pkg::*;
#(
  parameter logic [11:0] WORDS = WORDS_2K
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic incEn,
  input wire logic loadEn,
  input wire logic [PMM_PC_W-1:0] loadAddr,
  output logic [PMM_PC_W-1:0] pc_q
);

  localparam logic [PMM_PC_W-1:0] TOP_ADDR = PMM_PC_W'(WORDS - 12'h001);
  // the smallest power of two covering the store sets the counter width
  localparam logic [PMM_PC_W-1:0] PC_MASK =
    (WORDS > WORDS_1K) ? 11'h7FF : (WORDS > WORDS_512) ? 11'h3FF : 11'h1FF;

  logic [PMM_PC_W-1:0] masked;
  logic [PMM_PC_W-1:0] loadWrapped;

  always_comb
  begin
    masked = loadAddr & PC_MASK;
    // an address past the store folds back into it rather than faulting
    loadWrapped = (masked > TOP_ADDR) ? PMM_PC_W'(masked - WORDS[PMM_PC_W-1:0]) : masked;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pc_q <= TOP_ADDR;
    end
    else if (loadEn)
    begin
      pc_q <= loadWrapped;
    end
    else if (incEn)
    begin
      // top of the store rolls to zero, so a no-op at the vector restarts at 0
      pc_q <= (pc_q == TOP_ADDR) ? '0 : PMM_PC_W'((pc_q + 11'h001) & PC_MASK);
    end
  end

endmodule // pmm_prog_counter
`default_nettype wire

// ===== rtl/pmm_memory_map.sv
// program and data memory map: program counter, special and general file
`timescale 1ns/100ps
`default_nettype none
module pmm_memory_map
  import pmm_pkg::*;
#(
  parameter pmm_variant_t VARIANT = VAR_W2K
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  output pmm_quarter_t quarter,
  input wire logic [PMM_FA_W-1:0] fileAddr,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] opData,
  input wire logic flagInstr,
  input wire logic zeroWe,
  input wire logic zeroIn,
  input wire logic digitCarryWe,
  input wire logic digitCarryIn,
  input wire logic carryWe,
  input wire logic carryIn,
  input wire logic watchdogTimeout,
  input wire logic sleepExec,
  input wire logic watchdogClearExec,
  input wire logic pcIncEn,
  input wire logic jumpEn,
  input wire logic [8:0] jumpTarget,
  input wire logic returnEn,
  input wire logic [PMM_PC_W-1:0] returnAddr,
  output logic [PMM_PC_W-1:0] progAddr,
  output logic [7:0] flagsOut,
  input wire logic counterTick,
  output logic [7:0] realtimeCounter,
  input wire logic directionWe,
  input wire logic [PMM_FA_W-1:0] directionSel,
  input wire logic timerCfgWe,
  output logic [5:0] timerPrescalerCfg,
  input wire logic [FIRST_PORT_W-1:0] firstPortIn,
  output logic [FIRST_PORT_W-1:0] firstPortOut,
  output logic [FIRST_PORT_W-1:0] firstPortOe,
  input wire logic [7:0] secondPortIn,
  output logic [7:0] secondPortOut,
  output logic [7:0] secondPortOe,
  input wire logic [7:0] thirdPortIn,
  output logic [7:0] thirdPortOut,
  output logic [7:0] thirdPortOe
);

  // variant-derived structure
  localparam logic [11:0] PROG_WORDS =
    (VARIANT == VAR_W384) ? WORDS_384 :
    (VARIANT == VAR_W1K) ? WORDS_1K :
    (VARIANT == VAR_W2K || VARIANT == VAR_W2K_PORT3) ? WORDS_2K :
    WORDS_512;
  localparam bit HAS_THIRD_PORT = (VARIANT == VAR_W512_PORT3) || (VARIANT == VAR_W2K_PORT3);
  localparam bit HAS_BANKS = (VARIANT == VAR_W2K) || (VARIANT == VAR_W2K_PORT3);

  // quarter-cycle sequencer
  pmm_quarter_t quarter_q;
  logic readPhase;
  logic writePhase;
  logic fetchPhase;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      quarter_q <= QTR_FIRST;
    end
    else
    begin
      case (quarter_q)
        QTR_FIRST: quarter_q <= QTR_SECOND;
        QTR_SECOND: quarter_q <= QTR_THIRD;
        QTR_THIRD: quarter_q <= QTR_FOURTH;
        QTR_FOURTH: quarter_q <= QTR_FIRST;
        default: quarter_q <= QTR_FIRST;
      endcase
    end
  end

  assign quarter = quarter_q;
  assign readPhase = (quarter_q == QTR_SECOND);
  assign writePhase = (quarter_q == QTR_FOURTH);
  assign fetchPhase = (quarter_q == QTR_FIRST);

  // stored special registers
  logic [2:0] pageBits_q;
  logic [2:0] aluFlags_q;
  logic timeout_q;
  logic powerDown_q;
  logic [7:0] pointer_q;
  logic [7:0] counter_q;
  logic [FIRST_PORT_W-1:0] firstLatch_q;
  logic [7:0] secondLatch_q;
  logic [7:0] thirdLatch_q;
  logic [FIRST_PORT_W-1:0] firstDir_q;
  logic [7:0] secondDir_q;
  logic [7:0] thirdDir_q;
  logic [5:0] timerCfg_q;
  logic [PMM_PC_W-1:0] pc;

  // address decode shared by the read and write phases
  logic viaPointer;
  logic [6:0] effAddr;
  logic [4:0] low5;
  logic [1:0] bank;
  logic nullTarget;
  logic isGpr;
  logic [GPR_AW-1:0] gprIdx;
  logic fileWrite;

  always_comb
  begin
    viaPointer = (fileAddr == ADDR_INDIRECT_WINDOW);
    effAddr = viaPointer ? pointer_q[6:0] : {pointer_q[6:5], fileAddr};
    low5 = effAddr[4:0];
    bank = HAS_BANKS ? effAddr[6:5] : 2'h0;
    // pointing the window at itself reaches nothing
    nullTarget = (low5 == ADDR_INDIRECT_WINDOW);
    isGpr = (low5 >= ADDR_COMMON_GPR_BASE)
         || ((low5 == ADDR_THIRD_IO_PORT) && !HAS_THIRD_PORT);
    // upper half is banked on large parts, lower half is common
    gprIdx = low5[4] ? {1'b0, bank, low5[3:0]} : {GPR_COMMON_TAG, low5[3:0]};
    fileWrite = writePhase && wrEn && !nullTarget;
  end

  // special register read mux
  logic [7:0] sfrRead;

  always_comb
  begin
    case (low5)
      ADDR_REALTIME_COUNTER: sfrRead = counter_q;
      ADDR_PROGRAM_COUNTER_LOW: sfrRead = pc[7:0];
      ADDR_ALU_RESET_PAGE_FLAGS: sfrRead = {pageBits_q, timeout_q, powerDown_q, aluFlags_q};
      ADDR_INDIRECT_POINTER: sfrRead = HAS_BANKS ? {POINTER_FILL_BANKED, pointer_q[6:0]}
                                                 : {POINTER_FILL_UNBANKED, pointer_q[4:0]};
      ADDR_FIRST_IO_PORT: sfrRead = {FIRST_PORT_PAD, firstPortIn};
      ADDR_SECOND_IO_PORT: sfrRead = secondPortIn;
      ADDR_THIRD_IO_PORT: sfrRead = HAS_THIRD_PORT ? thirdPortIn : 8'h00;
      default: sfrRead = 8'h00;
    endcase
  end

  // operand capture in the second quarter
  logic [7:0] sfrRd_q;
  logic gprSel_q;
  logic [7:0] gprRd;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sfrRd_q <= 8'h00;
      gprSel_q <= 1'b0;
    end
    else if (readPhase)
    begin
      sfrRd_q <= nullTarget ? 8'h00 : sfrRead;
      gprSel_q <= isGpr && !nullTarget;
    end
  end

  assign opData = gprSel_q ? gprRd : sfrRd_q;

  pmm_gpr_mem #(
    .DEPTH(GPR_DEPTH),
    .AW(GPR_AW)
  ) u_gpr (
    .clk_sys(clk_sys),
    .rdEn(readPhase && isGpr),
    .rdAddr(gprIdx),
    .rdData_q(gprRd),
    .wrEn(fileWrite && isGpr),
    .wrAddr(gprIdx),
    .wrData(wrData)
  );

  // program counter: returns beat jumps, jumps beat writes to the low byte
  logic pcLoad;
  logic [PMM_PC_W-1:0] pcLoadAddr;

  always_comb
  begin
    pcLoad = 1'b0;
    pcLoadAddr = pc;
    if (writePhase && returnEn)
    begin
      pcLoad = 1'b1;
      pcLoadAddr = returnAddr;
    end
    else if (writePhase && jumpEn)
    begin
      pcLoad = 1'b1;
      // page bits supply the high address; 00 is the lowest 512-word page
      pcLoadAddr = {pageBits_q[1:0], jumpTarget};
    end
    else if (fileWrite && !isGpr && low5 == ADDR_PROGRAM_COUNTER_LOW)
    begin
      pcLoad = 1'b1;
      // bit 8 clears on a low-byte write, so computed jumps stay in page half
      pcLoadAddr = {pageBits_q[1:0], 1'b0, wrData};
    end
  end

  pmm_prog_counter #(
    .WORDS(PROG_WORDS)
  ) u_pc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .incEn(fetchPhase && pcIncEn),
    .loadEn(pcLoad),
    .loadAddr(pcLoadAddr),
    .pc_q(pc)
  );

  assign progAddr = pc;

  // page preselect bits take file writes as ordinary storage
  logic flagsTarget;

  assign flagsTarget = fileWrite && !isGpr && (low5 == ADDR_ALU_RESET_PAGE_FLAGS);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pageBits_q <= RST_PAGE_BITS;
    end
    else if (flagsTarget)
    begin
      pageBits_q <= wrData[FLAG_PAGE_MSB:FLAG_PAGE_LSB];
    end
  end

  // arithmetic flags: a flag-producing instruction masks the written data
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aluFlags_q <= 3'h0;
    end
    else if (writePhase)
    begin
      if (flagsTarget && !flagInstr)
      begin
        aluFlags_q <= wrData[FLAG_ZERO:FLAG_CARRY];
      end
      if (zeroWe)
      begin
        aluFlags_q[FLAG_ZERO] <= zeroIn;
      end
      if (digitCarryWe)
      begin
        aluFlags_q[FLAG_DIGIT_CARRY] <= digitCarryIn;
      end
      if (carryWe)
      begin
        aluFlags_q[FLAG_CARRY] <= carryIn;
      end
    end
  end

  // reset-cause flags never see file writes; a timeout beats a same-cycle clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timeout_q <= 1'b1;
      powerDown_q <= 1'b1;
    end
    else
    begin
      if (watchdogClearExec)
      begin
        timeout_q <= 1'b1;
        powerDown_q <= 1'b1;
      end
      if (sleepExec)
      begin
        timeout_q <= 1'b1;
        powerDown_q <= 1'b0;
      end
      if (watchdogTimeout)
      begin
        timeout_q <= 1'b0;
      end
    end
  end

  assign flagsOut = {pageBits_q, timeout_q, powerDown_q, aluFlags_q};

  // indirect pointer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pointer_q <= RST_INDIRECT_POINTER;
    end
    else if (fileWrite && !isGpr && low5 == ADDR_INDIRECT_POINTER)
    begin
      pointer_q <= wrData;
    end
  end

  // realtime counter value: a file write takes precedence over a tick
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      counter_q <= 8'h00;
    end
    else if (fileWrite && !isGpr && low5 == ADDR_REALTIME_COUNTER)
    begin
      counter_q <= wrData;
    end
    else if (counterTick)
    begin
      counter_q <= counter_q + 8'h01;
    end
  end

  assign realtimeCounter = counter_q;

  // output latches of the ports
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      firstLatch_q <= '0;
      secondLatch_q <= 8'h00;
      thirdLatch_q <= 8'h00;
    end
    else if (fileWrite && !isGpr)
    begin
      if (low5 == ADDR_FIRST_IO_PORT)
      begin
        firstLatch_q <= wrData[FIRST_PORT_W-1:0];
      end
      if (low5 == ADDR_SECOND_IO_PORT)
      begin
        secondLatch_q <= wrData;
      end
      if (HAS_THIRD_PORT && low5 == ADDR_THIRD_IO_PORT)
      begin
        thirdLatch_q <= wrData;
      end
    end
  end

  // direction and timer configuration: written only by dedicated strobes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      firstDir_q <= RST_PORT_DIRECTION[FIRST_PORT_W-1:0];
      secondDir_q <= RST_PORT_DIRECTION;
      thirdDir_q <= RST_PORT_DIRECTION;
    end
    else if (directionWe)
    begin
      if (directionSel == ADDR_FIRST_IO_PORT)
      begin
        firstDir_q <= wrData[FIRST_PORT_W-1:0];
      end
      if (directionSel == ADDR_SECOND_IO_PORT)
      begin
        secondDir_q <= wrData;
      end
      if (HAS_THIRD_PORT && directionSel == ADDR_THIRD_IO_PORT)
      begin
        thirdDir_q <= wrData;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timerCfg_q <= RST_TIMER_PRESCALER;
    end
    else if (timerCfgWe)
    begin
      timerCfg_q <= wrData[5:0];
    end
  end

  assign timerPrescalerCfg = timerCfg_q;

  // a direction bit of one makes the pin an input
  assign firstPortOut = firstLatch_q;
  assign firstPortOe = ~firstDir_q;
  assign secondPortOut = secondLatch_q;
  assign secondPortOe = ~secondDir_q;
  assign thirdPortOut = HAS_THIRD_PORT ? thirdLatch_q : 8'h00;
  assign thirdPortOe = HAS_THIRD_PORT ? ~thirdDir_q : 8'h00;

endmodule // pmm_memory_map
`default_nettype wire

// ===== verif/pmm_memory_map_asserts.sv
// concurrent checks on the memory map block ports
`timescale 1ns/100ps
`default_nettype none
module pmm_memory_map_asserts
  import pmm_pkg::*;
#(
  parameter pmm_variant_t VARIANT = VAR_W2K
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pmm_quarter_t quarter,
  input wire logic [PMM_FA_W-1:0] fileAddr,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic flagInstr,
  input wire logic zeroWe,
  input wire logic zeroIn,
  input wire logic watchdogTimeout,
  input wire logic sleepExec,
  input wire logic watchdogClearExec,
  input wire logic pcIncEn,
  input wire logic jumpEn,
  input wire logic [8:0] jumpTarget,
  input wire logic returnEn,
  input wire logic [7:0] opData,
  input wire logic [PMM_PC_W-1:0] progAddr,
  input wire logic [7:0] flagsOut,
  input wire logic [7:0] thirdPortOe
);
  localparam logic [10:0] TOP = VARIANT == VAR_W384 ? 11'h17F :
    (VARIANT == VAR_W512 || VARIANT == VAR_W512_PORT3) ? 11'h1FF :
    VARIANT == VAR_W1K ? 11'h3FF : 11'h7FF;
  // the 384-word wrap is not a mask, loads are only checked within the mask
  localparam logic [10:0] MASK = VARIANT == VAR_W384 ? 11'h1FF : TOP;
  localparam bit HAS_P3 = VARIANT == VAR_W512_PORT3 || VARIANT == VAR_W2K_PORT3;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_quarter_step: assert property (1'b1 |=> quarter == pmm_quarter_t'($past(quarter) + 2'h1))
    else $error("quarter did not advance by one");
  a_opdata_hold: assert property (quarter != QTR_SECOND |=> $stable(opData))
    else $error("operand changed outside the read quarter");
  a_pc_step: assert property (quarter == QTR_FIRST && pcIncEn |=>
    progAddr == ($past(progAddr) == TOP ? 11'h000 : $past(progAddr) + 11'h001))
    else $error("program counter step or wrap wrong");
  a_reset_vec: assert property ($fell(sys_rst) |-> progAddr == TOP && flagsOut == 8'h18)
    else $error("reset vector or reset flags wrong");
  a_flag_locked: assert property ($changed(flagsOut[4:3]) |->
    $past(watchdogTimeout || sleepExec || watchdogClearExec))
    else $error("reset cause flags changed without a cause");
  a_alu_mask: assert property (quarter == QTR_FOURTH && flagInstr &&
    fileAddr == ADDR_ALU_RESET_PAGE_FLAGS |=>
    flagsOut[2] == ($past(zeroWe) ? $past(zeroIn) : $past(flagsOut[2])))
    else $error("zero flag took written data");
  a_page_write: assert property (quarter == QTR_FOURTH && wrEn &&
    fileAddr == ADDR_ALU_RESET_PAGE_FLAGS |=> flagsOut[7:5] == $past(wrData[7:5]))
    else $error("page bits did not take written data");
  a_pcl_load: assert property (quarter == QTR_FOURTH && wrEn && !returnEn && !jumpEn &&
    fileAddr == ADDR_PROGRAM_COUNTER_LOW |=>
    progAddr == ({$past(flagsOut[6:5]), 1'b0, $past(wrData)} & MASK))
    else $error("counter low write loaded wrong address");
  a_jump_load: assert property (quarter == QTR_FOURTH && jumpEn && !returnEn |=>
    progAddr == ({$past(flagsOut[6:5]), $past(jumpTarget)} & MASK))
    else $error("jump ignored page bits");
  a_no_port3: assert property (!HAS_P3 |-> thirdPortOe == 8'h00)
    else $error("absent third port drives");
endmodule // pmm_memory_map_asserts

bind pmm_memory_map pmm_memory_map_asserts #(.VARIANT(VARIANT)) i_chk (
  .clk_sys, .sys_rst, .quarter, .fileAddr, .wrEn, .wrData, .flagInstr, .zeroWe, .zeroIn,
  .watchdogTimeout, .sleepExec, .watchdogClearExec, .pcIncEn, .jumpEn, .jumpTarget,
  .returnEn, .opData, .progAddr, .flagsOut, .thirdPortOe
);
`default_nettype wire

// ===== verif/pmm_cpu_model.sv
// partner model: cpu datapath issuing one file access per instruction cycle
`timescale 1ns/100ps
`default_nettype none
module pmm_cpu_model
  import pmm_pkg::*;
(
  input wire logic clk_sys,
  input wire pmm_quarter_t quarter,
  input wire logic [7:0] opData,
  output var logic [PMM_FA_W-1:0] fileAddr,
  output var logic [PMM_FA_W-1:0] directionSel,
  output var logic wrEn,
  output var logic directionWe,
  output var logic timerCfgWe,
  output var logic [7:0] wrData,
  output var logic flagInstr,
  output var logic [5:0] aluFlags,
  output var logic lost
);
  initial
  begin
    {fileAddr, directionSel, wrEn, directionWe, timerCfgWe, wrData} = '0;
    {flagInstr, aluFlags, lost} = '0;
  end

  // kind k: 0 read only, 1 file write, 2 direction write, 3 timer config
  task automatic exec(input logic [4:0] a, input logic [1:0] k, input logic [7:0] d,
    input logic [5:0] f, output logic [7:0] r);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (quarter !== QTR_FOURTH && n < 8);
    lost <= lost | (quarter !== QTR_FOURTH);
    fileAddr <= a;
    directionSel <= a;
    wrData <= d;
    wrEn <= (k == 2'h1);
    directionWe <= (k == 2'h2);
    timerCfgWe <= (k == 2'h3);
    aluFlags <= f;
    // any alu flag update marks the instruction as flag-affecting
    flagInstr <= f[5] | f[3] | f[1];
    repeat (3) @(posedge clk_sys);
    r = opData;
    @(posedge clk_sys);
    {wrEn, directionWe, timerCfgWe, flagInstr, aluFlags} <= '0;
  endtask
endmodule // pmm_cpu_model
`default_nettype wire

// ===== verif/pmm_memory_map_tb.sv
// self-checking testbench for the memory map block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module pmm_memory_map_tb
  import pmm_pkg::*;
;
  logic clk_sys, sys_rst, watchdogTimeout, sleepExec, watchdogClearExec, pcIncEn;
  logic jumpEn, returnEn, counterTick, wrEn, directionWe, timerCfgWe, flagInstr, lost;
  logic [8:0] jumpTarget;
  logic [PMM_PC_W-1:0] returnAddr, progAddr;
  logic [3:0] firstPortIn, firstPortOut, firstPortOe;
  logic [7:0] secondPortIn, thirdPortIn, wrData, opData, flagsOut, realtimeCounter, rdv;
  logic [7:0] secondPortOut, secondPortOe, thirdPortOut, thirdPortOe;
  logic [5:0] aluFlags, timerPrescalerCfg;
  logic [PMM_FA_W-1:0] fileAddr, directionSel;
  pmm_quarter_t quarter;
  wire logic zeroWe, zeroIn, digitCarryWe, digitCarryIn, carryWe, carryIn;
  int n_fail, cmp_count;
  assign {zeroWe, zeroIn, digitCarryWe, digitCarryIn, carryWe, carryIn} = aluFlags;

  pmm_memory_map #(.VARIANT(VAR_W2K)) i_dut (
    .clk_sys, .sys_rst, .quarter, .fileAddr, .wrEn, .wrData, .opData, .flagInstr,
    .zeroWe, .zeroIn, .digitCarryWe, .digitCarryIn, .carryWe, .carryIn, .watchdogTimeout,
    .sleepExec, .watchdogClearExec, .pcIncEn, .jumpEn, .jumpTarget, .returnEn, .returnAddr,
    .progAddr, .flagsOut, .counterTick, .realtimeCounter, .directionWe, .directionSel,
    .timerCfgWe, .timerPrescalerCfg, .firstPortIn, .firstPortOut, .firstPortOe,
    .secondPortIn, .secondPortOut, .secondPortOe, .thirdPortIn, .thirdPortOut, .thirdPortOe
  );
  pmm_cpu_model i_cpu (.clk_sys, .quarter, .opData, .fileAddr, .directionSel, .wrEn,
    .directionWe, .timerCfgWe, .wrData, .flagInstr, .aluFlags, .lost);

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a lost quarter alignment would make every later result meaningless
  task automatic ex(input logic [4:0] a, input logic [1:0] k, input logic [7:0] d,
    input logic [5:0] f = 6'h00);
    i_cpu.exec(a, k, d, f, rdv);
    if (lost)
    begin
      n_fail++;
      finish_test();
    end
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    ex(a, 2'h0, 8'h00);
    `CHK("file read", e, rdv)
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    ex(a, 2'h1, d);
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    `CHK("reset vector", 11'h7FF, progAddr)
    `CHK("reset flags", 8'h18, flagsOut)
  endtask

  task automatic t_pc();
    `CHK("direction reset", 12'h000, {firstPortOe, secondPortOe})
    `CHK("timer config reset", 6'h3F, timerPrescalerCfg)
    rd(ADDR_PROGRAM_COUNTER_LOW, 8'hFF);
    @(posedge clk_sys);
    pcIncEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pcIncEn <= 1'b0;
    @(negedge clk_sys);
    `CHK("counter wrap", 11'h000, progAddr)
  endtask

  task automatic t_flags();
    @(posedge clk_sys);
    sleepExec <= 1'b1;
    @(posedge clk_sys);
    sleepExec <= 1'b0;
    @(negedge clk_sys);
    `CHK("flags after sleep", 8'h10, flagsOut)
    wr(ADDR_ALU_RESET_PAGE_FLAGS, 8'hFF);
    `CHK("flags after write", 8'hF7, flagsOut)
    ex(ADDR_ALU_RESET_PAGE_FLAGS, 2'h1, 8'hFF, 6'h0A);
    `CHK("flags with alu result", 8'hF4, flagsOut)
    ex(ADDR_ALU_RESET_PAGE_FLAGS, 2'h1, 8'h00, 6'h30);
    `CHK("flags after clear", 8'h14, flagsOut)
    @(posedge clk_sys);
    watchdogTimeout <= 1'b1;
    @(posedge clk_sys);
    watchdogTimeout <= 1'b0;
    watchdogClearExec <= 1'b1;
    @(negedge clk_sys);
    `CHK("flags after timeout", 8'h04, flagsOut)
    @(posedge clk_sys);
    watchdogClearExec <= 1'b0;
    @(negedge clk_sys);
    `CHK("flags after watchdog clear", 8'h1C, flagsOut)
  endtask

  task automatic t_page();
    wr(ADDR_ALU_RESET_PAGE_FLAGS, 8'h40);
    @(posedge clk_sys);
    jumpTarget <= 9'h1A5;
    jumpEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    jumpEn <= 1'b0;
    @(negedge clk_sys);
    `CHK("jump in page two", 11'h5A5, progAddr)
    wr(ADDR_ALU_RESET_PAGE_FLAGS, 8'h60);
    wr(ADDR_PROGRAM_COUNTER_LOW, 8'h34);
    `CHK("counter low load", 11'h634, progAddr)
    rd(ADDR_PROGRAM_COUNTER_LOW, 8'h34);
    // a return carries all eleven counter bits
    @(posedge clk_sys);
    returnAddr <= 11'h7AB;
    returnEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    returnEn <= 1'b0;
    @(negedge clk_sys);
    `CHK("return load", 11'h7AB, progAddr)
  endtask

  task automatic t_indirect();
    wr(ADDR_INDIRECT_POINTER, 8'h30);
    wr(ADDR_INDIRECT_WINDOW, 8'hA5);
    rd(ADDR_INDIRECT_POINTER, 8'hB0);
    rd(5'h10, 8'hA5);
    wr(ADDR_INDIRECT_POINTER, 8'h10);
    wr(5'h10, 8'h5A);
    rd(ADDR_INDIRECT_WINDOW, 8'h5A);
    wr(ADDR_INDIRECT_POINTER, 8'h30);
    rd(5'h10, 8'hA5);
    wr(ADDR_INDIRECT_POINTER, 8'h68);
    wr(ADDR_INDIRECT_WINDOW, 8'hC3);
    wr(ADDR_INDIRECT_POINTER, 8'h00);
    wr(ADDR_INDIRECT_WINDOW, 8'h77);
    rd(ADDR_INDIRECT_WINDOW, 8'h00);
    rd(ADDR_COMMON_GPR_BASE, 8'hC3);
  endtask

  task automatic t_ports();
    @(posedge clk_sys);
    firstPortIn <= 4'hA;
    secondPortIn <= 8'h5C;
    ex(ADDR_FIRST_IO_PORT, 2'h2, 8'h00);
    ex(ADDR_SECOND_IO_PORT, 2'h2, 8'h0F);
    ex(ADDR_THIRD_IO_PORT, 2'h2, 8'h00);
    `CHK("port enables", 20'hFF000, {firstPortOe, secondPortOe, thirdPortOe})
    wr(ADDR_FIRST_IO_PORT, 8'hFF);
    `CHK("first port latch", 4'hF, firstPortOut)
    wr(ADDR_SECOND_IO_PORT, 8'hC6);
    `CHK("second port latch", 8'hC6, secondPortOut)
    rd(ADDR_FIRST_IO_PORT, 8'h0A);
    rd(ADDR_SECOND_IO_PORT, 8'h5C);
    wr(ADDR_THIRD_IO_PORT, 8'h3C);
    rd(ADDR_THIRD_IO_PORT, 8'h3C);
    `CHK("third port latch", 8'h00, thirdPortOut)
    ex(ADDR_INDIRECT_WINDOW, 2'h3, 8'h15);
    `CHK("timer config", 6'h15, timerPrescalerCfg)
  endtask

  task automatic t_counter();
    @(posedge clk_sys);
    counterTick <= 1'b1;
    repeat (3) @(posedge clk_sys);
    counterTick <= 1'b0;
    @(negedge clk_sys);
    `CHK("counter ticks", 8'h03, realtimeCounter)
    rd(ADDR_REALTIME_COUNTER, 8'h03);
    wr(ADDR_REALTIME_COUNTER, 8'h40);
    `CHK("counter written", 8'h40, realtimeCounter)
    rd(ADDR_REALTIME_COUNTER, 8'h40);
  endtask

  initial
  begin
    {sys_rst, watchdogTimeout, sleepExec, watchdogClearExec, pcIncEn} = 5'h10;
    {jumpEn, returnEn, counterTick, jumpTarget, returnAddr} = '0;
    {firstPortIn, secondPortIn, thirdPortIn} = '0;
    n_fail = 0;
    cmp_count = 0;
    do_reset();
    t_pc();
    t_flags();
    t_page();
    t_indirect();
    t_ports();
    t_counter();
    do_reset();
    finish_test();
  end
endmodule // pmm_memory_map_tb
`default_nettype wire
